//--- verif/lcr_top_test.sv
/* bench for the load current readout: reset values, selection, sums, hold.
   assumes lcr_top with a shortened measurement and inputs driven on falling edges. */
`timescale 1ns/1ps
module lcr_top_test;
    import lcr_pkg::*;
    logic       mclk, regWrite, regRead, fMas, sMas, measBusy;
    logic       sys_rst;
    logic [7:0] regAddr, regWdata, regRdata;
    logic [8:0] fCode, sCode;
    int         failCount = 0;
    int         comparisons = 0;
    // short measurement keeps the run brief
    lcr_top #(.MEAS_CYCLES(2)) lcr_top_i (.mclk(mclk), .sys_rst(sys_rst), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .firstCode(fCode), .secondCode(sCode), .firstIsMaster(fMas),
        .secondIsMaster(sMas), .measBusy(measBusy));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic chk(string what, logic [8:0] exp, logic [8:0] got);
        comparisons++;
        if (got !== exp) begin
            failCount++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge mclk);
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        @(negedge mclk);
        regWrite = 1'b0;
    endtask
    // read data is registered, so it is taken two falling edges after the read edge
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        regRead = 1'b1;
        regAddr = a;
        @(negedge mclk);
        regRead = 1'b0;
        @(negedge mclk);
        d = regRdata;
    endtask
    task automatic measure(logic sel, logic [8:0] exp, string what);
        logic [7:0] h, l, s;
        int         n;
        wr(8'h24, {7'h50, sel});
        @(negedge mclk);
        chk("busy", 9'h001, {8'h00, measBusy});
        n = 0;
        while (measBusy !== 1'b0 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        chk("busy end", 9'h000, {8'h00, measBusy});
        rd(8'h25, h);
        rd(8'h26, l);
        rd(8'h24, s);
        chk("select", {1'b0, 7'h50, sel}, {1'b0, s});
        chk("high reserved", 9'h000, {2'b00, h[7:1]});
        chk(what, exp, {h[0], l});
        $display("test %s done", what);
    endtask
    task automatic reset_test();
        logic [7:0] d;
        rd(8'h25, d);
        chk("high reset", 9'h000, {1'b0, d});
        wr(8'h26, 8'hff);
        rd(8'h26, d);
        chk("low reset", 9'h001, {1'b0, d});
        rd(8'h24, d);
        chk("select reset", 9'h000, {1'b0, d});
        rd(8'h40, d);
        chk("unmapped", 9'h000, {1'b0, d});
        $display("test reset done");
    endtask
    task automatic hold_test();
        logic [7:0] d;
        fMas = 1'b0;
        fCode = 9'h155;
        wr(8'h24, 8'h00);
        rd(8'h26, d);
        chk("low while busy", 9'h003, {1'b0, d});
        measure(1'b0, 9'h155, "after hold");
    endtask
    // master on the second phase with a sum beyond the nine bit ceiling
    task automatic clip_test();
        {fMas, sMas, fCode, sCode} = {2'b01, 9'h1ff, 9'h010};
        measure(1'b1, 9'h1ff, "master clip");
    endtask
    // reset in mid measurement abandons it and restores the reset result
    task automatic reset_mid_test();
        logic [7:0] h, l;
        {fMas, fCode} = {1'b0, 9'h0c0};
        wr(8'h24, 8'h00);
        sys_rst = 1'b1;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        chk("busy after reset", 9'h000, {8'h00, measBusy});
        rd(8'h25, h);
        rd(8'h26, l);
        chk("result after reset", 9'h001, {h[0], l});
        $display("test reset mid done");
    endtask
    task automatic printVerdict();
        $display("comparisons %0d failCount %0d", comparisons, failCount);
        if (failCount == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog of 5000 cycles, well beyond the hundred or so cycles the tests need
    initial begin
        #20000;
        failCount++;
        printVerdict();
    end
    initial begin
        {regWrite, regRead, fMas, sMas} = '0;
        {regAddr, regWdata, fCode, sCode} = '0;
        sys_rst = 1'b1;
        repeat (20) @(negedge mclk);
        sys_rst = 1'b0;
        reset_test();
        fCode = 9'h1a5;
        measure(1'b0, 9'h1a5, "single first");
        {fMas, sMas, fCode, sCode} = {2'b10, 9'h0aa, 9'h1c3};
        measure(1'b1, 9'h1c3, "slave second");
        {fCode, sCode} = {9'h0f0, 9'h013};
        measure(1'b0, 9'h103, "master sum");
        hold_test();
        clip_test();
        reset_mid_test();
        printVerdict();
    end
endmodule

//--- verilog/lcr_map.svh
/*
 * register offsets, field positions, reset values and timing counts of the
 * load current readout. assumes inclusion by bare name from design files.
 */
`ifndef LCR_MAP_SVH
`define LCR_MAP_SVH

`define LCR_OFF_SELECT      8'h24
`define LCR_OFF_HIGH        8'h25
`define LCR_OFF_LOW         8'h26
`define LCR_SEL_BIT         0
`define LCR_RST_SELECT      8'h00
`define LCR_RST_HIGH        8'h00
`define LCR_RST_LOW         8'h01
`define LCR_CODE_W          9
`define LCR_STEP_MA         20
`define LCR_MEAS_CYCLES     16

`endif

//--- verilog/lcr_meas_if.sv
/*
 * carrier between the readout top and its sum stage.
 * assumes one clock domain.
 */
`timescale 1ns/1ps
interface lcr_meas_if;
    logic       selSecond;
    logic [8:0] code;
    modport top (output selSecond, input code);
    modport sum (input selSecond, output code);
endinterface

//--- verilog/lcr_pkg.sv
/*
 * types of the load current readout.
 * assumes nothing beyond a sv compiler.
 */
package lcr_pkg;
    typedef enum logic [0:0] {
        LCR_IDLE = 1'b0,
        LCR_MEAS = 1'b1
    } lcr_state_t;
endpackage

//--- verilog/lcr_sum.sv
/*
 * combines per-phase current codes into the reported code.
 * assumes phase codes and phase roles arrive on mclk.
 */
`timescale 1ns/1ps
module lcr_sum
    import lcr_pkg::*;
(
    // phase data
    input  wire logic [8:0] firstCode,
    input  wire logic [8:0] secondCode,
    input  wire logic       firstIsMaster,
    input  wire logic       secondIsMaster,
    // carrier
    lcr_meas_if.sum         meas
);
    logic [9:0] sumWide;

    // master reports both phases; saturate at the nine bit ceiling of 10.22 A
    always_comb begin
        sumWide = {1'b0, firstCode} + {1'b0, secondCode};
        if (meas.selSecond ? secondIsMaster : firstIsMaster) begin
            meas.code = sumWide[9] ? 9'h1ff : sumWide[8:0];
        end else begin
            meas.code = meas.selSecond ? secondCode : firstCode;
        end
    end
endmodule

//--- verilog/lcr_top.sv
/*
 * load current readout: selection register, measurement sequencer and the
 * two read-only result registers, on a byte wide register port. the sum
 * stage that merges master and slave phase codes sits in lcr_sum.
 * assumes the register port and the phase monitor inputs are on mclk, so
 * none of them is synchronised here; the measurement length is a parameter
 * because the real conversion time is not known.
 */
`timescale 1ns/1ps
`include "lcr_map.svh"

module lcr_top
    import lcr_pkg::*;
#(
    parameter int MEAS_CYCLES = `LCR_MEAS_CYCLES
)
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // register port
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    // phase monitors
    input  wire logic [8:0] firstCode,
    input  wire logic [8:0] secondCode,
    input  wire logic       firstIsMaster,
    input  wire logic       secondIsMaster,
    // status
    output logic            measBusy
);
    lcr_meas_if meas ();

    // sequencer state, select copy and the registered result
    lcr_state_t  state_q, state_d;
    logic [7:0]  select_q, select_d;
    logic [8:0]  result_q, result_d;
    logic [15:0] cnt_q, cnt_d;
    logic        busy_q, busy_d;
    // read data and port decode
    logic [7:0]  rdata_q, rdata_d;
    logic        selWrite;
    // check helpers, read only by the assertions at the bottom
    logic [15:0] busyAge_q, busyAge_d;
    logic [9:0]  sumCheck;

    assign selWrite = regWrite && regAddr == `LCR_OFF_SELECT;
    assign meas.selSecond = select_q[`LCR_SEL_BIT];

    lcr_sum lcr_sum_i (
        .firstCode      (firstCode),
        .secondCode     (secondCode),
        .firstIsMaster  (firstIsMaster),
        .secondIsMaster (secondIsMaster),
        .meas           (meas)
    );

    // sequencer next state; a write mid-measurement restarts the count
    always_comb begin
        state_d  = state_q;
        select_d = select_q;
        result_d = result_q;
        cnt_d    = cnt_q;
        if (selWrite) begin
            select_d = regWdata; // reserved bits are r/w, kept as written
            state_d  = LCR_MEAS;
            cnt_d    = 16'(MEAS_CYCLES - 1);
        end else begin
            case (state_q)
                LCR_IDLE: begin
                    cnt_d = cnt_q;
                end
                LCR_MEAS: begin
                    if (cnt_q == 16'h0000) begin
                        result_d = meas.code;
                        state_d  = LCR_IDLE;
                    end else begin
                        cnt_d = cnt_q - 16'h0001;
                    end
                end
                default: state_d = LCR_IDLE;
            endcase
        end
        // busy is registered beside the state so the pin needs no decode
        busy_d = state_d == LCR_MEAS;
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = rdata_q;
        if (regRead) begin
            case (regAddr)
                `LCR_OFF_SELECT: rdata_d = select_q;
                `LCR_OFF_HIGH:   rdata_d = {7'h00, result_q[8]};
                `LCR_OFF_LOW:    rdata_d = result_q[7:0];
                default:         rdata_d = 8'h00;
            endcase
        end
    end

    // sequencer registers; reset abandons any measurement in flight
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q  <= LCR_IDLE;
            select_q <= `LCR_RST_SELECT;
            result_q <= {1'(`LCR_RST_HIGH), 8'(`LCR_RST_LOW)};
            cnt_q    <= 16'h0000;
            busy_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            select_q <= select_d;
            result_q <= result_d;
            cnt_q    <= cnt_d;
            busy_q   <= busy_d;
        end
    end

    // read data register; holding it between reads lets a slow reader sample late
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // both outputs come straight from flops
    assign regRdata = rdata_q;
    assign measBusy = busy_q;

    // busy age: cycles spent measuring since the last start
    always_comb begin
        busyAge_d = busyAge_q;
        if (selWrite || !busy_q) begin
            busyAge_d = 16'h0000;
        end else if (busyAge_q != 16'hffff) begin
            busyAge_d = busyAge_q + 16'h0001; // stops at the top, never wraps
        end
    end

    // busy age register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            busyAge_q <= 16'h0000;
        end else begin
            busyAge_q <= busyAge_d;
        end
    end

    // full width phase sum, so an overflow is visible to the checks
    assign sumCheck = {1'b0, firstCode} + {1'b0, secondCode};

    // select writes: each one starts work and lands its bits
    a_write_starts: assert property (@(posedge mclk) disable iff (sys_rst)
        selWrite |=> measBusy)
        else $error("select write did not start");
    a_select_bit: assert property (@(posedge mclk) disable iff (sys_rst)
        selWrite |=> meas.selSecond == $past(regWdata[0]))
        else $error("select bit not taken");
    a_select_kept: assert property (@(posedge mclk) disable iff (sys_rst)
        selWrite |=> select_q == $past(regWdata))
        else $error("select register not written");

    // result register: held while measuring or idle, loaded once at the end,
    // and a measurement never outlives its programmed length
    a_result_held: assert property (@(posedge mclk) disable iff (sys_rst)
        (measBusy && cnt_q != 16'h0000) || selWrite |=> $stable(result_q))
        else $error("result changed mid measurement");
    a_result_load: assert property (@(posedge mclk) disable iff (sys_rst)
        measBusy && cnt_q == 16'h0000 && !selWrite |=> result_q == $past(meas.code))
        else $error("result not loaded at end");
    a_idle_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        !measBusy && !selWrite |=> $stable(result_q))
        else $error("result changed while idle");
    a_busy_falls: assert property (@(posedge mclk) disable iff (sys_rst)
        measBusy && cnt_q == 16'h0000 && !selWrite |=> !measBusy)
        else $error("busy did not fall at end");
    a_busy_bound: assert property (@(posedge mclk) disable iff (sys_rst)
        busyAge_q <= 16'(MEAS_CYCLES))
        else $error("measurement ran too long");

    // read port: both halves of the result, and data that stands between reads
    a_high_read: assert property (@(posedge mclk) disable iff (sys_rst)
        regRead && regAddr == `LCR_OFF_HIGH |=> regRdata == {7'h00, $past(result_q[8])})
        else $error("high register wrong");
    a_low_read: assert property (@(posedge mclk) disable iff (sys_rst)
        regRead && regAddr == `LCR_OFF_LOW |=> regRdata == $past(result_q[7:0]))
        else $error("low register wrong");
    a_read_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        !regRead |=> $stable(regRdata))
        else $error("read data moved without a read");

    // sum stage: a master reports both phases, clipped at the nine bit
    // ceiling; a slave reports its own phase only
    a_master_sum: assert property (@(posedge mclk) disable iff (sys_rst)
        !meas.selSecond && firstIsMaster && !sumCheck[9]
        |-> meas.code == sumCheck[8:0])
        else $error("master sum wrong");
    a_sum_second: assert property (@(posedge mclk) disable iff (sys_rst)
        meas.selSecond && secondIsMaster && !sumCheck[9]
        |-> meas.code == sumCheck[8:0])
        else $error("second master sum wrong");
    a_sum_clip: assert property (@(posedge mclk) disable iff (sys_rst)
        sumCheck[9] && ((!meas.selSecond && firstIsMaster) || (meas.selSecond && secondIsMaster))
        |-> meas.code == 9'h1ff)
        else $error("master sum not clipped");
    a_slave_own: assert property (@(posedge mclk) disable iff (sys_rst)
        meas.selSecond && !secondIsMaster |-> meas.code == secondCode)
        else $error("slave code wrong");
    a_first_own: assert property (@(posedge mclk) disable iff (sys_rst)
        !meas.selSecond && !firstIsMaster |-> meas.code == firstCode)
        else $error("first slave code wrong");
endmodule
